// *** hdl/eeprom_defs.svh ***
// constants and functional notes for the two-wire eeprom target
// Functional notes
// - data changes only while clock low; changes while clock high are start or stop
// - falling data with clock high is start; parsing restarts on it
// - rising data with clock high is stop; ends transfer, back to standby
// - bytes are eight bits; device acks each received byte on ninth clock
// - standby at power-up and after stop once internal work is done
// - start, nine clocks, start, stop leaves device ready for fresh transfer
// - first byte after start is device address; top nibble fixed pattern
// - next three address bits must match the three select straps
// - last address bit picks direction: one read, zero write
// - match acks low; mismatch gives no ack, idles until next start
// - byte write: word address, one data byte, both acked, then stop
// - after write stop, self-timed program cycle up to 5 ms, no acks
// - page write: up to seven more bytes acked, then stop
// - write address increments low three bits only, wrapping in page
// - polling during program cycle acked only after programming ends
// - address counter holds last accessed address plus one between operations
// - read address wraps from last byte of array to first byte
// - current read shifts out byte at counter after acked read address
// - controller ack continues sequential read; no ack then stop ends it
// - sample on clock rise, change output after clock fall
// - array is sixteen pages of eight bytes, seven-bit address
// - write-protect high protects the whole array
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH
`define DEV_CLASS_CODE 4'ha
`define PAGE_BYTES 8
`define PAGE_COUNT 16
`define PROGRAM_CYCLE_TIME_US 5000
`define MCLK_MHZ 10
`define PROGRAM_CYCLE_CYCLES (`PROGRAM_CYCLE_TIME_US * `MCLK_MHZ)
`endif

// *** hdl/eeprom_pkg.sv ***
// types for the two-wire eeprom target
package eeprom_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV = 3'b001,
    ST_WADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_IGNORE = 3'b101
  } phase_t;
endpackage

// *** hdl/two_wire_eeprom_target.sv ***
// two-wire serial eeprom target: bus parsing, page buffer, program timer
`timescale 1ns/1ps
`include "eeprom_defs.svh"
module two_wire_eeprom_target #(
  parameter int PROG_CYCLES = `PROGRAM_CYCLE_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // straps
  input wire logic select_strap_bit2,
  input wire logic select_strap_bit1,
  input wire logic select_strap_bit0,
  input wire logic write_protect,
  // status
  output logic busy
);
  import eeprom_pkg::*;

  // two-flop synchronisers for every pin
  logic [1:0] scl_s_r, sda_s_r, wp_s_r;
  logic [2:0] sel_s1_r, sel_s2_r;
  logic scl_d_r, sda_d_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      wp_s_r <= 2'h0;
      sel_s1_r <= 3'h0;
      sel_s2_r <= 3'h0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      wp_s_r <= {wp_s_r[0], write_protect};
      sel_s1_r <= {select_strap_bit2, select_strap_bit1, select_strap_bit0};
      sel_s2_r <= sel_s1_r;
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end

  // synchronised levels and the edges found between them
  logic scl, sda, scl_rise, scl_fall, start_ev, stop_ev;
  assign scl = scl_s_r[1];
  assign sda = sda_s_r[1];
  assign scl_rise = scl & ~scl_d_r;
  assign scl_fall = ~scl & scl_d_r;
  // data edges while clock stays high are framing, not bits
  assign start_ev = scl & scl_d_r & sda_d_r & ~sda;
  assign stop_ev = scl & scl_d_r & ~sda_d_r & sda;

  // array storage and page buffer (two-entry write buffer beneath)
  logic [7:0] mem_r [0:`PAGE_COUNT*`PAGE_BYTES-1];
  logic [7:0] page_r [0:`PAGE_BYTES-1];
  logic [`PAGE_BYTES-1:0] pvalid_r, pvalid_nxt;

  // bus state
  phase_t phase_r, phase_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [6:0] addr_r, addr_nxt;
  logic ack_r, ack_nxt;
  logic drive_r, drive_nxt;
  logic pend_r, pend_nxt;
  logic [31:0] timer_r, timer_nxt;
  logic commit_r, commit_nxt;
  logic [3:0] cidx_r, cidx_nxt;
  logic [7:0] obyte_r, obyte_nxt;

  // two-entry skid buffer between page buffer and array writer
  logic [14:0] fifo_r [0:1];
  logic [1:0] fcnt_r, fcnt_nxt;
  logic frd_r, frd_nxt, fwr_r, fwr_nxt;
  logic fin_valid, fin_ready, fout_valid, fout_ready;
  logic [14:0] fin_data;
  // limitation: the array writer never stalls, so the buffer never fills
  assign fin_ready = (fcnt_r != 2'h2);
  assign fout_valid = (fcnt_r != 2'h0);
  assign fout_ready = 1'b1; // array accepts one word per cycle

  // committing page entries into the array once the program timer expires
  always_comb begin
    cidx_nxt = cidx_r;
    commit_nxt = commit_r;
    fin_valid = 1'b0;
    fin_data = {addr_r[6:3], 3'h0, 8'h00};
    if (commit_r) begin
      if (cidx_r == 4'(`PAGE_BYTES)) begin
        commit_nxt = 1'b0;
      end else begin
        fin_valid = pvalid_r[cidx_r[2:0]];
        fin_data = {addr_r[6:3], cidx_r[2:0], page_r[cidx_r[2:0]]};
        if (!fin_valid || fin_ready) begin
          cidx_nxt = cidx_r + 4'h1; // back-pressure holds the index
        end
      end
    end
    // timer expiry restarts the commit walk at entry zero
    if (timer_r == 32'h1) begin
      commit_nxt = 1'b1;
      cidx_nxt = 4'h0;
    end
  end

  // pointers flip per transfer; count moves by push minus pop
  always_comb begin
    fcnt_nxt = fcnt_r;
    frd_nxt = frd_r;
    fwr_nxt = fwr_r;
    if (fin_valid && fin_ready) begin
      fwr_nxt = ~fwr_r;
    end
    if (fout_valid && fout_ready) begin
      frd_nxt = ~frd_r;
    end
    fcnt_nxt = fcnt_r + 2'((fin_valid && fin_ready) ? 1 : 0)
      - 2'((fout_valid && fout_ready) ? 1 : 0);
  end

  // skid buffer occupancy and pointers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fcnt_r <= 2'h0;
      frd_r <= 1'b0;
      fwr_r <= 1'b0;
    end else begin
      fcnt_r <= fcnt_nxt;
      frd_r <= frd_nxt;
      fwr_r <= fwr_nxt;
    end
  end

  // storage arrays have no reset
  always_ff @(posedge mclk) begin
    if (fin_valid && fin_ready) begin
      fifo_r[fwr_r] <= fin_data;
    end
    if (fout_valid && fout_ready) begin
      mem_r[fifo_r[frd_r][14:8]] <= fifo_r[frd_r][7:0];
    end
    if (phase_r == ST_WDATA && scl_rise && bit_r == 4'h7) begin
      page_r[addr_r[2:0]] <= {shift_r[6:0], sda};
    end
  end

  // bus protocol next state
  always_comb begin
    phase_nxt = phase_r;
    bit_nxt = bit_r;
    shift_nxt = shift_r;
    addr_nxt = addr_r;
    ack_nxt = ack_r;
    drive_nxt = drive_r;
    pend_nxt = pend_r;
    pvalid_nxt = pvalid_r;
    timer_nxt = timer_r;
    obyte_nxt = obyte_r;
    // program timer counts down to the end of the write cycle
    if (timer_r != 32'h0) begin
      timer_nxt = timer_r - 32'h1;
    end
    // page flags clear first, so a byte landing now keeps its flag
    if (commit_r && (cidx_r == 4'(`PAGE_BYTES))) begin
      pvalid_nxt = '0;
    end
    // a start abandons the byte and phase in flight; buffered page bytes stay pending
    if (start_ev) begin
      phase_nxt = ST_DEV;
      bit_nxt = 4'h0;
      drive_nxt = 1'b0;
      ack_nxt = 1'b0;
    end else if (stop_ev) begin
      drive_nxt = 1'b0;
      ack_nxt = 1'b0;
      phase_nxt = ST_IDLE;
      // programming only starts if a data byte arrived
      if (pend_r && pvalid_r != '0) begin
        if (!wp_s_r[1]) begin
          timer_nxt = 32'(PROG_CYCLES);
        end else begin
          pvalid_nxt = '0;
        end
      end
      pend_nxt = 1'b0;
    end else if (phase_r != ST_IDLE && phase_r != ST_IGNORE) begin
      if (scl_rise) begin
        if (bit_r < 4'h8) begin
          shift_nxt = {shift_r[6:0], sda};
          bit_nxt = bit_r + 4'h1;
        end else if (phase_r == ST_RDATA) begin
          // ninth clock of a read: the controller answers, not us
          // the counter steps past every byte sent, acked or not
          addr_nxt = addr_r + 7'h1;
          if (sda) begin
            phase_nxt = ST_IGNORE;
          end
          bit_nxt = 4'h0;
        end else begin
          bit_nxt = 4'h0;
          if (!ack_r && phase_r == ST_DEV) begin
            phase_nxt = ST_IGNORE;
          end
        end
      end
      if (scl_fall) begin
        // outgoing data changes after the falling edge
        // our ack is decided on the fall that ends the eighth bit
        if (bit_r == 4'h8 && phase_r != ST_RDATA) begin
          unique case (phase_r)
            ST_DEV: begin
              ack_nxt = (shift_r[7:4] == `DEV_CLASS_CODE) &&
                (shift_r[3:1] == sel_s2_r) &&
                (timer_r == 32'h0) && !commit_r;
            end
            ST_WADDR: begin
              addr_nxt = shift_r[6:0];
              ack_nxt = 1'b1;
            end
            default: begin
              ack_nxt = 1'b1;
            end
          endcase
          drive_nxt = ack_nxt;
        end else if (bit_r == 4'h0 && ack_r) begin
          // ack clock over: let go and move to the next phase
          drive_nxt = 1'b0;
          ack_nxt = 1'b0;
          unique case (phase_r)
            ST_DEV: phase_nxt = shift_r[0] ? ST_RDATA : ST_WADDR;
            ST_WADDR: phase_nxt = ST_WDATA;
            default: phase_nxt = phase_r;
          endcase
          if (phase_r == ST_DEV && shift_r[0]) begin
            obyte_nxt = mem_r[addr_r];
            drive_nxt = ~mem_r[addr_r][7];
          end
        end else if (phase_r == ST_RDATA) begin
          // read data leaves msb first, one bit per fall
          if (bit_r == 4'h0) begin
            obyte_nxt = mem_r[addr_r];
            drive_nxt = ~mem_r[addr_r][7];
          end else if (bit_r < 4'h8) begin
            drive_nxt = ~obyte_r[3'(4'h7 - bit_r)];
          end else begin
            drive_nxt = 1'b0; // release for controller ack
          end
        end else begin
          drive_nxt = 1'b0;
        end
      end
      // byte write into the page buffer, low bits wrap in page
      if (phase_r == ST_WDATA && scl_rise && bit_r == 4'h7) begin
        pvalid_nxt[addr_r[2:0]] = 1'b1;
        addr_nxt = {addr_r[6:3], addr_r[2:0] + 3'h1};
        pend_nxt = 1'b1;
      end
    end
  end

  // bus protocol and commit state registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= ST_IDLE;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      addr_r <= 7'h00;
      ack_r <= 1'b0;
      drive_r <= 1'b0;
      pend_r <= 1'b0;
      pvalid_r <= '0;
      timer_r <= 32'h0;
      commit_r <= 1'b0;
      cidx_r <= 4'h0;
      obyte_r <= 8'h00;
    end else begin
      phase_r <= phase_nxt;
      bit_r <= bit_nxt;
      shift_r <= shift_nxt;
      addr_r <= addr_nxt;
      ack_r <= ack_nxt;
      drive_r <= drive_nxt;
      pend_r <= pend_nxt;
      pvalid_r <= pvalid_nxt;
      timer_r <= timer_nxt;
      commit_r <= commit_nxt;
      cidx_r <= cidx_nxt;
      obyte_r <= obyte_nxt;
    end
  end

  // open drain: only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe = drive_r;
  // busy covers the timer and the commit walk after it
  assign busy = (timer_r != 32'h0) | commit_r;
endmodule

// *** tb/eeprom_chk_sva.sv ***
// pin-level checks for the two-wire eeprom target
`timescale 1ns/1ps
module eeprom_chk #(
  parameter int PROG_CYCLES = 200
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // bus and status
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_i,
  input wire logic sda_oe,
  input wire logic busy
);
  int cnt_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // length of the current busy run, so its bounds can be checked
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cnt_r <= 0;
    else cnt_r <= busy ? cnt_r + 1 : 0;
  end
  rst_quiet_a: assert property (
    $rose(rst_n) |-> !sda_oe && !busy) else $error("drive after reset");
  open_drain_a: assert property (
    sda_o == 1'b0) else $error("data driven high");
  drive_on_a: assert property (
    $rose(sda_oe) |-> !$past(scl_i) || !$past(scl_i, 2) || !$past(scl_i, 3))
    else $error("drive began in clock high");
  drive_off_a: assert property (
    $fell(sda_oe) |-> !$past(scl_i) || !$past(scl_i, 2) || !$past(scl_i, 3))
    else $error("drive ended in clock high");
  busy_quiet_a: assert property (
    busy |-> !sda_oe) else $error("answer while busy");
  busy_min_a: assert property (
    $fell(busy) |-> cnt_r >= PROG_CYCLES) else $error("cycle too short");
  busy_max_a: assert property (
    busy |-> cnt_r < PROG_CYCLES + 64) else $error("cycle too long");
  busy_stop_a: assert property (
    $rose(busy) |-> scl_i && sda_i) else $error("cycle without stop");
endmodule
bind two_wire_eeprom_target eeprom_chk #(.PROG_CYCLES(PROG_CYCLES))
  eeprom_chk_inst (.mclk, .rst_n, .scl_i, .sda_o, .sda_i, .sda_oe, .busy);

// *** tb/ctl.sv ***
// behavioural bus controller on a pulled-up open-drain data wire
`timescale 1ns/1ps
module ctl (
  // clock
  input wire logic mclk,
  // device pull-down
  input wire logic dev_oe,
  // bus wires
  output logic scl,
  output logic sda
);
  logic pull = 1'b0;
  initial scl = 1'b1;
  // released wire floats high through the pull-up
  assign sda = ~(pull | dev_oe);
  task automatic tk(int n);
    repeat (n) @(posedge mclk);
  endtask
  // data moves only mid-way through clock low
  task automatic bx(input logic b, output logic s);
    pull <= ~b;
    tk(2);
    scl <= 1'b1;
    tk(2);
    s = sda;
    tk(2);
    scl <= 1'b0;
    tk(2);
  endtask
  task automatic start();
    pull <= 1'b0;
    tk(2);
    scl <= 1'b1;
    tk(2);
    pull <= 1'b1;
    tk(2);
    scl <= 1'b0;
    tk(2);
  endtask
  // long idle after stop, bus stays high
  task automatic stop();
    pull <= 1'b1;
    tk(2);
    scl <= 1'b1;
    tk(2);
    pull <= 1'b0;
    tk(8);
  endtask
  task automatic wr(input logic [7:0] d, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) bx(d[i], s);
    bx(1'b1, nack);
  endtask
  // acks every byte but the last
  task automatic rd(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bx(1'b1, d[i]);
    bx(last, s);
  endtask
endmodule

// *** tb/two_wire_eeprom_target_tb.sv ***
// self-checking bench for the two-wire eeprom target
`timescale 1ns/1ps
module two_wire_eeprom_target_tb;
  logic mclk, rst_n, scl, sda, wp, oe, bz, a;
  logic [2:0] sel;
  logic [7:0] lf;
  logic [7:0] mem [128];
  int error_cnt = 0;
  int n_compared = 0;
  two_wire_eeprom_target #(.PROG_CYCLES(200)) two_wire_eeprom_target_inst (
    .mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe(oe), .select_strap_bit2(sel[2]), .select_strap_bit1(sel[1]),
    .select_strap_bit0(sel[0]), .write_protect(wp), .busy(bz));
  ctl ctl_inst (.mclk(mclk), .dev_oe(oe), .scl(scl), .sda(sda));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // device word: fixed class nibble, straps, direction
  function automatic logic [7:0] dw(input logic r);
    return {4'ha, sel, r};
  endfunction
  task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic seek(logic [7:0] w);
    ctl_inst.start();
    ctl_inst.wr(dw(1'b0), a);
    cmp("ack dev", 8'h00, {7'h0, a});
    ctl_inst.wr(w, a);
    cmp("ack adr", 8'h00, {7'h0, a});
  endtask
  // ten bytes: the last two land on the first two offsets written again
  task automatic wpage(logic [6:0] b);
    seek({1'b0, b});
    for (int i = 0; i < 10; i++) begin
      lf = nx(lf);
      ctl_inst.wr(lf, a);
      cmp("ack data", 8'h00, {7'h0, a});
      if (!wp) mem[{b[6:3], 3'(b[2:0] + i)}] = lf;
    end
    ctl_inst.stop();
  endtask
  task automatic poll();
    int k;
    k = 0;
    a = 1'b1;
    while (a && k < 40) begin
      ctl_inst.start();
      ctl_inst.wr(dw(1'b0), a);
      ctl_inst.stop();
      k++;
    end
    if (a) error_cnt++;
    if (a) give_verdict();
    cmp("refused", 8'h01, {7'h0, k > 1});
  endtask
  task automatic rseq(int n, logic [6:0] b);
    logic [7:0] v;
    ctl_inst.start();
    ctl_inst.wr(dw(1'b1), a);
    cmp("ack rd", 8'h00, {7'h0, a});
    for (int i = 0; i < n; i++) begin
      ctl_inst.rd(i == n - 1, v);
      cmp("rdata", mem[7'(b + i)], v);
    end
    ctl_inst.stop();
  endtask
  initial begin
    rst_n = 1'b0;
    wp = 1'b0;
    lf = nx(8'h4f);
    sel = lf[2:0];
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    // fill the last and the first page from random offsets
    wpage({4'hf, lf[5:3]});
    poll();
    wpage({4'h0, lf[4:2]});
    poll();
    $display("page writes done");
    wp <= 1'b1;
    wpage(7'h01);
    repeat (30) @(posedge mclk);
    cmp("busy", 8'h00, {7'h0, bz});
    wp <= 1'b0;
    // top word address bit set; read runs over the array end
    seek(8'hff);
    rseq(3, 7'h7f);
    rseq(1, 7'h02);
    $display("reads done");
    for (int i = 0; i < 2; i++) begin
      ctl_inst.start();
      ctl_inst.wr(i ? {4'h5, sel, 1'b1} : {4'ha, ~sel, 1'b0}, a);
      cmp("nack", 8'h01, {7'h0, a});
      ctl_inst.stop();
    end
    ctl_inst.start();
    repeat (9) ctl_inst.bx(1'b1, a);
    ctl_inst.start();
    ctl_inst.stop();
    rseq(1, 7'h03);
    $display("address and recovery done");
    give_verdict();
  end
endmodule
